// ===== hdl/ocds_pkg.sv
// Shared constants and types for the output channel diagnostic status block.
// Assumes a 32-bit AXI4-Lite register bus and at most eight channels.
package ocds_pkg;

    localparam int NUM_CH_DEFAULT = 8;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [4:0] OFF_CH_ENABLE = 5'h00;
    localparam logic [4:0] OFF_CH_MODE = 5'h04;
    localparam logic [4:0] OFF_DIAG_STATUS = 5'h08;
    localparam logic [4:0] OFF_FLAGS_A = 5'h0C;
    localparam logic [4:0] OFF_FLAGS_B = 5'h10;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

    // Reset values, counter wrap target and counter step
    localparam logic [7:0] CH_ENABLE_RESET = 8'hFF;
    localparam logic [7:0] CH_MODE_RESET = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COUNTER_WRAP_TO = 8'h01;
    localparam logic [7:0] COUNTER_STEP = 8'h01;

    // Field positions
    localparam int POS_ANY = 0;
    localparam int POS_COUNT = 8;
    localparam int POS_BAD = 0;
    localparam int POS_UNCERTAIN = 8;
    localparam int POS_OPEN = 16;
    localparam int POS_SHORT = 24;
    localparam int POS_HOT = 0;
    localparam int POS_FIELD = 8;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_COUNT = 0;
    localparam int IRQ_RISE = 1;
    localparam int IRQ_FALL = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel mode bit: set means current output, clear means voltage output
    localparam logic MODE_CURRENT = 1'h1;

    typedef struct packed {
        logic bad;
        logic uncertain;
        logic open_wire_flag;
        logic output_short_flag;
        logic module_hot_flag;
        logic field_supply_missing_flag;
    } ocds_chan_flags_t;

    typedef struct packed {
        logic open_wire;
        logic output_short;
        logic module_hot;
        logic field_supply_missing;
        logic out_of_range;
        logic offset_invalid;
        logic cal_fault;
    } ocds_chan_sense_t;

    typedef enum logic [0:0] {
        OCDS_BUS_IDLE = 1'h0,
        OCDS_BUS_BUSY = 1'h1
    } ocds_bus_state_t;

endpackage

// ===== hdl/ocds_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/10ps
`default_nettype none
module ocds_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
        if (!reset_n) begin
            next_stage1 = '0;
            next_sync_out = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end

endmodule
`default_nettype wire

// ===== hdl/ocds_top.sv
// Per-channel diagnostic flags, any-diagnostic flag, event counter and IRQ.
// Assumes raw sense levels from detection circuits on pins, AXI4-Lite master.
// Operation
// RULE1: Any-diagnostic flag high while any diagnostic active
// RULE2: Count each condition detect and each clear
// RULE3: Counter cleared to zero by reset
// RULE4: Counter wraps from all ones to one
// RULE5: Counter signed eight bit, zero only after reset
// RULE6: Bad flag for disabled, open or shorted; code also sets it for missing field supply
// RULE7: Bad and uncertain flags clear without acknowledge
// RULE8: Uncertain flag for range, heat, offset, calibration
// RULE9: Open-wire flag for disconnected wire or terminal
// RULE10: Open wire judged only in current mode
// RULE11: Short flag judged only in voltage mode
// RULE12: Over-temperature flag follows module heat
// RULE13: Field supply flag high while supply absent
// RULE14: Any flag ORs flags of enabled channels
// RULE15: Simultaneous edges each advance counter once
`timescale 1ns/10ps
`default_nettype none
module ocds_top #(
    parameter int NUM_CH = ocds_pkg::NUM_CH_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire ocds_pkg::ocds_chan_sense_t [NUM_CH-1:0] sense_raw,
    input wire logic [ocds_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ocds_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ocds_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ocds_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output ocds_pkg::ocds_chan_flags_t [NUM_CH-1:0] chan_flags,
    output logic any_diag_flag,
    output logic signed [7:0] diag_event_counter,
    output logic irq
);

    localparam int FLAG_W = $bits(ocds_pkg::ocds_chan_flags_t);
    localparam int SENSE_W = $bits(ocds_pkg::ocds_chan_sense_t);
    localparam int EDGE_W = $clog2(NUM_CH * FLAG_W + 1);

    // Adds n single steps to the counter, skipping zero on every step
    function automatic logic [7:0] skip_add(input logic [7:0] c, input logic [EDGE_W-1:0] n);
        logic [7:0] v;
        v = c;
        for (int i = 0; i < NUM_CH * FLAG_W; i++) begin
            if (i < int'(n)) begin
                v = v + ocds_pkg::COUNTER_STEP; // see RULE15
                if (v == ocds_pkg::COUNTER_RESET) begin
                    v = ocds_pkg::COUNTER_WRAP_TO; // see RULE4
                end
            end
        end
        return v;
    endfunction

    // Number of set bits in a flag vector
    function automatic logic [EDGE_W-1:0] count_ones(input logic [NUM_CH*FLAG_W-1:0] x);
        logic [EDGE_W-1:0] s;
        s = '0;
        for (int i = 0; i < NUM_CH * FLAG_W; i++) begin
            s = s + EDGE_W'(x[i]);
        end
        return s;
    endfunction

    ocds_pkg::ocds_chan_sense_t [NUM_CH-1:0] sense;

    ocds_sync #(
        .WIDTH(NUM_CH * SENSE_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(sense_raw),
        .sync_out(sense)
    );

    // Software state
    logic [NUM_CH-1:0] ch_enable;
    logic [NUM_CH-1:0] ch_mode;
    localparam int IRQ_W_L = ocds_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] irq_status;
    logic [IRQ_W_L-1:0] irq_mask;
    logic [NUM_CH-1:0] next_ch_enable;
    logic [NUM_CH-1:0] next_ch_mode;
    logic [IRQ_W_L-1:0] next_irq_status;
    logic [IRQ_W_L-1:0] next_irq_mask;

    // Diagnostic state
    ocds_pkg::ocds_chan_flags_t [NUM_CH-1:0] next_chan_flags;
    logic next_any_diag_flag;
    logic [7:0] next_diag_event_counter;
    logic [EDGE_W-1:0] edge_count;
    logic [IRQ_W_L-1:0] irq_event;

    // Bus state
    ocds_pkg::ocds_bus_state_t wr_state;
    ocds_pkg::ocds_bus_state_t next_wr_state;
    ocds_pkg::ocds_bus_state_t rd_state;
    ocds_pkg::ocds_bus_state_t next_rd_state;
    logic aw_have;
    logic next_aw_have;
    logic w_have;
    logic next_w_have;
    logic [ocds_pkg::ADDR_W-1:0] aw_addr;
    logic [ocds_pkg::ADDR_W-1:0] next_aw_addr;
    logic [ocds_pkg::DATA_W-1:0] w_data;
    logic [ocds_pkg::DATA_W-1:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp;
    logic [ocds_pkg::DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;

    assign s_axi_awready = (wr_state == ocds_pkg::OCDS_BUS_IDLE) && !aw_have;
    assign s_axi_wready = (wr_state == ocds_pkg::OCDS_BUS_IDLE) && !w_have;
    assign s_axi_bvalid = (wr_state == ocds_pkg::OCDS_BUS_BUSY);
    assign s_axi_arready = (rd_state == ocds_pkg::OCDS_BUS_IDLE);
    assign s_axi_rvalid = (rd_state == ocds_pkg::OCDS_BUS_BUSY);
    assign irq = |(irq_status & irq_mask);
    assign do_write = aw_have && w_have && (wr_state == ocds_pkg::OCDS_BUS_IDLE);

    // Flag evaluation and counter
    always_comb begin
        next_any_diag_flag = 1'h0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            next_chan_flags[ch].open_wire_flag = ch_enable[ch] && sense[ch].open_wire
                && (ch_mode[ch] == ocds_pkg::MODE_CURRENT); // see RULE9 see RULE10
            next_chan_flags[ch].output_short_flag = ch_enable[ch] && sense[ch].output_short
                && (ch_mode[ch] != ocds_pkg::MODE_CURRENT); // see RULE11
            next_chan_flags[ch].module_hot_flag = sense[ch].module_hot; // see RULE12
            next_chan_flags[ch].field_supply_missing_flag =
                sense[ch].field_supply_missing; // see RULE13
            // Levels only, so each flag drops as soon as its cause goes (see RULE7)
            next_chan_flags[ch].bad = !ch_enable[ch]
                || next_chan_flags[ch].open_wire_flag
                || next_chan_flags[ch].output_short_flag
                || next_chan_flags[ch].field_supply_missing_flag; // see RULE6
            next_chan_flags[ch].uncertain = ch_enable[ch] && (sense[ch].out_of_range
                || sense[ch].module_hot || sense[ch].offset_invalid
                || sense[ch].cal_fault); // see RULE8
            if (ch_enable[ch] && (|next_chan_flags[ch])) begin
                next_any_diag_flag = 1'h1; // see RULE1 see RULE14
            end
        end
        edge_count = count_ones(next_chan_flags ^ chan_flags); // see RULE2
        next_diag_event_counter = skip_add(diag_event_counter, edge_count); // see RULE5
        irq_event = '0;
        irq_event[ocds_pkg::IRQ_COUNT] = (edge_count != '0);
        irq_event[ocds_pkg::IRQ_RISE] = next_any_diag_flag && !any_diag_flag;
        irq_event[ocds_pkg::IRQ_FALL] = !next_any_diag_flag && any_diag_flag;
        if (!reset_n) begin
            next_chan_flags = '0;
            next_any_diag_flag = 1'h0;
            next_diag_event_counter = ocds_pkg::COUNTER_RESET; // see RULE3
        end
    end

    always_ff @(posedge clk_sys) begin
        chan_flags <= next_chan_flags;
        any_diag_flag <= next_any_diag_flag;
        diag_event_counter <= next_diag_event_counter;
    end

    // Software registers, interrupt status with set winning over clear
    always_comb begin
        next_ch_enable = ch_enable;
        next_ch_mode = ch_mode;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (do_write && w_strb[0]) begin
            case (aw_addr)
                ocds_pkg::OFF_CH_ENABLE: begin
                    next_ch_enable = w_data[NUM_CH-1:0];
                end
                ocds_pkg::OFF_CH_MODE: begin
                    next_ch_mode = w_data[NUM_CH-1:0];
                end
                ocds_pkg::OFF_IRQ_STATUS: begin
                    next_irq_status = irq_status & ~w_data[IRQ_W_L-1:0];
                end
                ocds_pkg::OFF_IRQ_MASK: begin
                    next_irq_mask = w_data[IRQ_W_L-1:0];
                end
                default: begin
                end
            endcase
        end
        next_irq_status = next_irq_status | irq_event;
        if (!reset_n) begin
            next_ch_enable = ocds_pkg::CH_ENABLE_RESET[NUM_CH-1:0];
            next_ch_mode = ocds_pkg::CH_MODE_RESET[NUM_CH-1:0];
            next_irq_status = '0;
            next_irq_mask = ocds_pkg::IRQ_MASK_RESET;
        end
    end

    always_ff @(posedge clk_sys) begin
        ch_enable <= next_ch_enable;
        ch_mode <= next_ch_mode;
        irq_status <= next_irq_status;
        irq_mask <= next_irq_mask;
    end

    // Write channel: address and data taken in either order
    always_comb begin
        next_wr_state = wr_state;
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'h1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'h1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_have = 1'h0;
            next_w_have = 1'h0;
            next_wr_state = ocds_pkg::OCDS_BUS_BUSY;
            case (aw_addr)
                ocds_pkg::OFF_CH_ENABLE, ocds_pkg::OFF_CH_MODE, ocds_pkg::OFF_DIAG_STATUS,
                ocds_pkg::OFF_FLAGS_A, ocds_pkg::OFF_FLAGS_B, ocds_pkg::OFF_IRQ_STATUS,
                ocds_pkg::OFF_IRQ_MASK: begin
                    next_bresp = ocds_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = ocds_pkg::RESP_SLVERR;
                end
            endcase
        end
        if ((wr_state == ocds_pkg::OCDS_BUS_BUSY) && s_axi_bready) begin
            next_wr_state = ocds_pkg::OCDS_BUS_IDLE;
        end
        if (!reset_n) begin
            next_wr_state = ocds_pkg::OCDS_BUS_IDLE;
            next_aw_have = 1'h0;
            next_w_have = 1'h0;
            next_aw_addr = '0;
            next_w_data = '0;
            next_w_strb = '0;
            next_bresp = ocds_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys) begin
        wr_state <= next_wr_state;
        aw_have <= next_aw_have;
        w_have <= next_w_have;
        aw_addr <= next_aw_addr;
        w_data <= next_w_data;
        w_strb <= next_w_strb;
        s_axi_bresp <= next_bresp;
    end

    // Read channel
    always_comb begin
        next_rd_state = rd_state;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rd_state = ocds_pkg::OCDS_BUS_BUSY;
            next_rdata = '0;
            next_rresp = ocds_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ocds_pkg::OFF_CH_ENABLE: begin
                    next_rdata[NUM_CH-1:0] = ch_enable;
                end
                ocds_pkg::OFF_CH_MODE: begin
                    next_rdata[NUM_CH-1:0] = ch_mode;
                end
                ocds_pkg::OFF_DIAG_STATUS: begin
                    next_rdata[ocds_pkg::POS_ANY] = any_diag_flag;
                    next_rdata[ocds_pkg::POS_COUNT +: 8] = diag_event_counter;
                end
                ocds_pkg::OFF_FLAGS_A: begin
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        next_rdata[ocds_pkg::POS_BAD + ch] = chan_flags[ch].bad;
                        next_rdata[ocds_pkg::POS_UNCERTAIN + ch] = chan_flags[ch].uncertain;
                        next_rdata[ocds_pkg::POS_OPEN + ch] = chan_flags[ch].open_wire_flag;
                        next_rdata[ocds_pkg::POS_SHORT + ch] = chan_flags[ch].output_short_flag;
                    end
                end
                ocds_pkg::OFF_FLAGS_B: begin
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        next_rdata[ocds_pkg::POS_HOT + ch] = chan_flags[ch].module_hot_flag;
                        next_rdata[ocds_pkg::POS_FIELD + ch] =
                            chan_flags[ch].field_supply_missing_flag;
                    end
                end
                ocds_pkg::OFF_IRQ_STATUS: begin
                    next_rdata[IRQ_W_L-1:0] = irq_status;
                end
                ocds_pkg::OFF_IRQ_MASK: begin
                    next_rdata[IRQ_W_L-1:0] = irq_mask;
                end
                default: begin
                    next_rresp = ocds_pkg::RESP_SLVERR;
                end
            endcase
        end
        if ((rd_state == ocds_pkg::OCDS_BUS_BUSY) && s_axi_rready) begin
            next_rd_state = ocds_pkg::OCDS_BUS_IDLE;
        end
        if (!reset_n) begin
            next_rd_state = ocds_pkg::OCDS_BUS_IDLE;
            next_rdata = '0;
            next_rresp = ocds_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_state <= next_rd_state;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
    end

endmodule
`default_nettype wire

// ===== verification/ocds_top_asserts.sv
// Checker for the diagnostic flags and the event counter of ocds_top.
// Assumes it is bound to ocds_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module ocds_top_asserts #(
    parameter int NUM_CH = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire ocds_pkg::ocds_chan_sense_t [NUM_CH-1:0] sense_raw,
    input wire ocds_pkg::ocds_chan_flags_t [NUM_CH-1:0] chan_flags,
    input wire logic any_diag_flag,
    input wire logic signed [7:0] diag_event_counter
);
    logic [NUM_CH-1:0] bad_v, unc_v, open_v, short_v, hot_v, field_v;
    logic [NUM_CH-1:0] s_open, s_short, s_hot, s_field, s_unc;
    logic [1:0] age;
    logic [1:0] next_age;

    // Counter advance by n steps, never landing on zero
    function automatic logic [7:0] bump(input logic [7:0] c, input int n);
        logic [7:0] v;
        v = c;
        for (int k = 0; k < n; k++) begin
            v = (v == 8'hFF) ? 8'h01 : v + 8'h01;
        end
        return v;
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            bad_v[i] = chan_flags[i].bad;
            unc_v[i] = chan_flags[i].uncertain;
            open_v[i] = chan_flags[i].open_wire_flag;
            short_v[i] = chan_flags[i].output_short_flag;
            hot_v[i] = chan_flags[i].module_hot_flag;
            field_v[i] = chan_flags[i].field_supply_missing_flag;
            s_open[i] = sense_raw[i].open_wire;
            s_short[i] = sense_raw[i].output_short;
            s_hot[i] = sense_raw[i].module_hot;
            s_field[i] = sense_raw[i].field_supply_missing;
            s_unc[i] = sense_raw[i].out_of_range | sense_raw[i].module_hot |
                sense_raw[i].offset_invalid | sense_raw[i].cal_fault;
        end
        // Cycles since reset release, saturating
        next_age = (age == 2'h3) ? age : age + 2'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            age <= 2'h0;
        end else begin
            age <= next_age;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_live;
        age != 2'h0;
    endsequence
    sequence s_settled;
        age == 2'h3;
    endsequence

    a_any_quiet: assert property ((chan_flags == '0) |-> !any_diag_flag)
        else $error("any flag high with no channel flag");
    a_any_raise: assert property (|(unc_v | open_v | short_v) |-> any_diag_flag)
        else $error("any flag low with an enabled channel flag");
    a_count_cleared: assert property (
        $rose(reset_n) |-> diag_event_counter == 8'h00)
        else $error("counter not zero after reset");
    a_count_nonzero: assert property (
        (diag_event_counter != 8'h00) |=> (diag_event_counter != 8'h00))
        else $error("counter reached zero");
    a_count_steps: assert property (s_live |-> diag_event_counter ==
        bump($past(diag_event_counter), $countones(chan_flags ^ $past(chan_flags))))
        else $error("counter step differs from flag changes");
    a_open_cause: assert property ((open_v & ~$past(s_open, 3)) == '0)
        else $error("open wire flag without sensed open wire");
    a_short_cause: assert property ((short_v & ~$past(s_short, 3)) == '0)
        else $error("short flag without sensed short");
    a_unc_cause: assert property ((unc_v & ~$past(s_unc, 3)) == '0)
        else $error("uncertain flag without a cause");
    a_hot_follow: assert property (s_settled |-> hot_v == $past(s_hot, 3))
        else $error("heat flag does not follow its sense");
    a_field_follow: assert property (s_settled |-> field_v == $past(s_field, 3))
        else $error("field supply flag does not follow its sense");
    a_bad_cover: assert property (((open_v | short_v | field_v) & ~bad_v) == '0)
        else $error("bad flag low with a fault flag set");
endmodule

bind ocds_top ocds_top_asserts #(.NUM_CH(NUM_CH)) ocds_top_asserts_inst (.*);
`default_nettype wire

// ===== verification/ocds_host.sv
// AXI4-Lite master model standing for the host controller.
// Assumes one clock shared with the slave; callers use the wr and rd tasks.
`timescale 1ns/10ps
`default_nettype none
module ocds_host (
    input wire logic clk_sys,
    output logic [ocds_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [ocds_pkg::DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ocds_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ocds_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        s_axi_awaddr = 5'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 5'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // Released payloads show the inverse so stale values never look valid
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== verification/ocds_top_test.sv
// Self-checking bench for the output channel diagnostic status block.
// Assumes the host model for bus traffic and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module ocds_top_test;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    ocds_pkg::ocds_chan_sense_t [7:0] sense_raw = '0;
    ocds_pkg::ocds_chan_flags_t [7:0] chan_flags;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic any_diag_flag, irq;
    logic signed [7:0] diag_event_counter;
    logic [7:0] exp_cnt = 8'h00;
    int mismatches = 0;
    int total_checks = 0;

    always #25 clk_sys = ~clk_sys;

    ocds_top #(.NUM_CH(8)) ocds_top_inst (.*);

    ocds_host host_inst (.*);

    function automatic logic [7:0] bump(input logic [7:0] c, input int n);
        logic [7:0] v;
        v = c;
        for (int k = 0; k < n; k++) begin
            v = (v == 8'hFF) ? 8'h01 : v + 8'h01;
        end
        return v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic chk_cnt();
        chk({24'h0, diag_event_counter}, {24'h0, exp_cnt});
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [1:0] r;
        host_inst.wr(a, d, r);
        chk(32'(r), 32'(ocds_pkg::RESP_OKAY));
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] want, input logic [1:0] rw);
        logic [31:0] d;
        logic [1:0] r;
        host_inst.rd(a, d, r);
        chk(d, want);
        chk(32'(r), 32'(rw));
    endtask

    task automatic put(input int ch, input int b, input logic v);
        @(posedge clk_sys);
        sense_raw[ch][b] <= v;
        repeat (4) @(posedge clk_sys);
    endtask

    // Raise one sense bit, judge flags and counter, drop it and judge again
    task automatic t_cause(input int ch, input int b, input logic [5:0] f, input int n);
        put(ch, b, 1'b1);
        exp_cnt = bump(exp_cnt, n);
        chk(32'(chan_flags[ch]), 32'(f));
        chk(32'(any_diag_flag), 32'(f != 6'h00));
        chk_cnt();
        put(ch, b, 1'b0);
        exp_cnt = bump(exp_cnt, n);
        chk(32'(chan_flags[ch]), 32'h0);
        chk(32'(any_diag_flag), 32'h0);
        chk_cnt();
    endtask

    task automatic t_regs();
        rd(ocds_pkg::OFF_CH_ENABLE, 32'hFF, ocds_pkg::RESP_OKAY);
        rd(ocds_pkg::OFF_CH_MODE, 32'h0, ocds_pkg::RESP_OKAY);
        rd(ocds_pkg::OFF_IRQ_MASK, 32'h0, ocds_pkg::RESP_OKAY);
        rd(5'h1C, 32'h0, ocds_pkg::RESP_SLVERR);
        rd(ocds_pkg::OFF_DIAG_STATUS, 32'h0, ocds_pkg::RESP_OKAY);
    endtask

    task automatic t_disable();
        wr(ocds_pkg::OFF_CH_ENABLE, 32'hDF);
        exp_cnt = bump(exp_cnt, 1);
        chk(32'(chan_flags[5]), 32'h20);
        chk(32'(any_diag_flag), 32'h0);
        rd(ocds_pkg::OFF_DIAG_STATUS, {16'h0, exp_cnt, 8'h00}, ocds_pkg::RESP_OKAY);
        wr(ocds_pkg::OFF_CH_ENABLE, 32'hFF);
        exp_cnt = bump(exp_cnt, 1);
        chk_cnt();
    endtask

    // Eight bad flags flip per write; enough writes to pass the wrap once
    task automatic t_wrap();
        for (int i = 0; i < 34; i++) begin
            wr(ocds_pkg::OFF_CH_ENABLE, i[0] ? 32'hFF : 32'h00);
            exp_cnt = bump(exp_cnt, 8);
            chk_cnt();
        end
    endtask

    task automatic t_irq();
        rd(ocds_pkg::OFF_IRQ_STATUS, 32'h7, ocds_pkg::RESP_OKAY);
        chk(32'(irq), 32'h0);
        wr(ocds_pkg::OFF_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(ocds_pkg::OFF_IRQ_STATUS, 32'h7);
        chk(32'(irq), 32'h0);
        rd(ocds_pkg::OFF_IRQ_STATUS, 32'h0, ocds_pkg::RESP_OKAY);
        put(7, 5, 1'b1);
        exp_cnt = bump(exp_cnt, 2);
        chk(32'(irq), 32'h1);
        rd(ocds_pkg::OFF_IRQ_STATUS, 32'h3, ocds_pkg::RESP_OKAY);
        put(7, 5, 1'b0);
        exp_cnt = bump(exp_cnt, 2);
        chk_cnt();
    endtask

    task automatic t_reset();
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        exp_cnt = 8'h00;
        chk_cnt();
        reset_n <= 1'b1;
    endtask

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        wr(ocds_pkg::OFF_CH_MODE, 32'h1);
        t_cause(0, 6, 6'h28, 2);
        t_cause(1, 6, 6'h00, 0);
        t_cause(1, 5, 6'h24, 2);
        t_cause(0, 5, 6'h00, 0);
        for (int b = 0; b < 3; b++) begin
            t_cause(2, b, 6'h10, 1);
        end
        t_cause(3, 4, 6'h12, 2);
        t_cause(4, 3, 6'h21, 2);
        t_disable();
        t_wrap();
        t_irq();
        t_reset();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
